// ### acmp_defines.svh
// Constants for the analog comparator control block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef ACMP_DEFINES_SVH
`define ACMP_DEFINES_SVH

// Register port widths
`define ACMP_ADDR_W 4
`define ACMP_DATA_W 8

// Register offsets
`define ACMP_OFS_SC 4'h0
`define ACMP_OFS_IRQ_STATUS 4'h1
`define ACMP_OFS_IRQ_MASK 4'h2

// Status/control field positions
`define ACMP_SC_ENABLE 7
`define ACMP_SC_REF_SEL 6
`define ACMP_SC_FLAG 5
`define ACMP_SC_IRQ_EN 4
`define ACMP_SC_LEVEL 3
`define ACMP_SC_PIN_EN 2
`define ACMP_SC_MODE_HI 1
`define ACMP_SC_MODE_LO 0

// Interrupt status/mask field position
`define ACMP_IRQ_EVENT 0

// Edge mode encodings
`define ACMP_MODE_FALL0 2'h0
`define ACMP_MODE_RISE 2'h1
`define ACMP_MODE_FALL2 2'h2
`define ACMP_MODE_BOTH 2'h3

// Reset values
`define ACMP_RST_BIT 1'h0
`define ACMP_RST_MODE 2'h0
`define ACMP_RST_BYTE 8'h00
`define ACMP_RST_SYNC 3'h0

// Synchroniser stage positions
`define ACMP_SYNC_S1 0
`define ACMP_SYNC_S2 1
`define ACMP_SYNC_S3 2

`endif

// ### acmp_pkg.sv
// Types shared by the analog comparator control block.
// Assumes acmp_defines.svh is on the include path.
`include "acmp_defines.svh"

package acmp_pkg;

    // Register port request from software
    typedef struct packed {
        logic [`ACMP_ADDR_W-1:0] addr;
        logic [`ACMP_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Power and debug state of the processor
    typedef struct packed {
        logic wait_mode;
        logic stop2_mode;
        logic stop3_mode;
        logic debug_active;
    } power_mode_t;

    // Controls toward the analog comparator cell
    typedef struct packed {
        logic power_on;
        logic plus_from_pin;
        logic plus_from_bandgap;
        logic minus_from_pin;
    } analog_ctl_t;

    // Digital output pin of the comparator
    typedef struct packed {
        logic value;
        logic oe;
    } pin_out_t;

    // Synchroniser state
    typedef struct packed {
        logic [2:0] stage;
        logic level;
    } sync_state_t;

    // Whole state of the control block
    typedef struct packed {
        logic enable;
        logic ref_sel;
        logic flag;
        logic irq_en;
        logic pin_en;
        logic [1:0] edge_mode;
        logic armed;
        logic prev_level;
        logic pin_value;
        logic pin_oe;
        logic evt_status;
        logic evt_mask;
        logic [`ACMP_DATA_W-1:0] rdata;
    } acmp_state_t;

endpackage : acmp_pkg

// ### acmp_sync3.sv
// Three-stage synchroniser with agreement filter for one level.
// Assumes the input is asynchronous to clk.
`include "acmp_defines.svh"

module acmp_sync3 (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level and its filtered copy
    input wire logic async_in,
    output logic level
);
    import acmp_pkg::*;

    sync_state_t state_ff;
    sync_state_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.stage = {state_ff.stage[`ACMP_SYNC_S2:`ACMP_SYNC_S1], async_in};
        // Change counts once the second and third stages agree
        if (state_ff.stage[`ACMP_SYNC_S2] == state_ff.stage[`ACMP_SYNC_S3])
        begin
            nxt_state.level = state_ff.stage[`ACMP_SYNC_S3];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= '{stage: `ACMP_RST_SYNC, level: `ACMP_RST_BIT};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign level = state_ff.level;

endmodule : acmp_sync3

// ### analog_comparator_control.sv
// Control and event logic around one analog voltage comparator.
// Assumes power mode inputs come from logic on clk; comparator result is asynchronous.
//
// Overview of operation
// - Enabled comparator keeps comparing and detecting edges during wait mode.
// - Compare event in wait raises the interrupt when interrupt enable is set.
// - Comparator inactive in every stop mode, so never a stop wake-up source.
// - Stop2 powers the block off; on wake everything is at reset values.
// - Stop3 freezes clocks and holds registers except read data and output pin, which clear; comparator low power, no compares.
// - Stop3 exit by reset resets; exit by interrupt resumes held state.
// - Block runs normally, including flag setting, in active background debug.
// - Minus pin always inverting input; plus pin non-inverting when reference_select 0.
// - Output pin enable drives comparator result on the output pin, else not.
// - Event detector triggers on rising, falling or either edge.
// - One 8-bit status/control register with the fixed field layout.
// - Flag set on each selected event; write one clears, write zero ignored.
// - Edge mode: 00 falling, 01 rising, 10 falling, 11 either edge.
// - Output level bit reads live result; reads zero while comparator disabled.
// - Interrupt asserted while flag set and interrupt enable set.
`include "acmp_defines.svh"

module analog_comparator_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire acmp_pkg::reg_req_t req,
    output logic [`ACMP_DATA_W-1:0] rdata,
    // Processor power and debug state
    input wire acmp_pkg::power_mode_t mode,
    // Analog comparator cell
    input wire logic cmp_result,
    output acmp_pkg::analog_ctl_t analog_ctl,
    // Comparator output pin
    output acmp_pkg::pin_out_t out_pin,
    // Interrupt request
    output logic irq
);
    import acmp_pkg::*;

    acmp_state_t state_ff;
    acmp_state_t nxt_state;
    acmp_state_t reset_state;

    logic live_level;
    logic stopped;
    logic active;
    logic rise;
    logic fall;
    logic event_hit;
    logic sel_sc;
    logic sel_status;
    logic sel_mask;
    logic wr_sc;
    logic wr_mask;
    logic rd_status;
    logic [`ACMP_DATA_W-1:0] sc_view;
    logic [`ACMP_DATA_W-1:0] read_mux;

    // Level lags the pin by about four clocks
    // sync comparator result
    acmp_sync3 u_sync (
        .clk(clk),
        .rst(rst),
        .async_in(cmp_result),
        .level(live_level)
    );

    assign stopped = mode.stop2_mode | mode.stop3_mode;

    assign active = state_ff.enable & ~stopped;

    assign rise = state_ff.armed & live_level & ~state_ff.prev_level;
    assign fall = state_ff.armed & ~live_level & state_ff.prev_level;

    always_comb
    begin
        event_hit = 1'h0;
        case (state_ff.edge_mode)
            `ACMP_MODE_RISE:
            begin
                event_hit = rise;
            end
            `ACMP_MODE_BOTH:
            begin
                event_hit = rise | fall;
            end
            `ACMP_MODE_FALL0,
            `ACMP_MODE_FALL2:
            begin
                event_hit = fall;
            end
            default:
            begin
                event_hit = fall;
            end
        endcase
        if (!active)
        begin
            event_hit = 1'b0;
        end
    end

    // Address decode
    assign sel_sc = (req.addr == `ACMP_OFS_SC);
    assign sel_status = (req.addr == `ACMP_OFS_IRQ_STATUS);
    assign sel_mask = (req.addr == `ACMP_OFS_IRQ_MASK);

    // Qualified strobes
    assign wr_sc = req.wr & sel_sc;
    assign wr_mask = req.wr & sel_mask;
    assign rd_status = req.rd & sel_status;

    always_comb
    begin
        sc_view = `ACMP_RST_BYTE;
        sc_view[`ACMP_SC_ENABLE] = state_ff.enable;
        sc_view[`ACMP_SC_REF_SEL] = state_ff.ref_sel;
        sc_view[`ACMP_SC_FLAG] = state_ff.flag;
        sc_view[`ACMP_SC_IRQ_EN] = state_ff.irq_en;
        sc_view[`ACMP_SC_LEVEL] = state_ff.enable & live_level;
        sc_view[`ACMP_SC_PIN_EN] = state_ff.pin_en;
        sc_view[`ACMP_SC_MODE_HI:`ACMP_SC_MODE_LO] = state_ff.edge_mode;
    end

    // Status and mask use bit 0 only
    // Read data selection; unmapped offsets read zero
    always_comb
    begin
        read_mux = `ACMP_RST_BYTE;
        if (sel_sc)
        begin
            read_mux = sc_view;
        end
        else if (sel_status)
        begin
            read_mux[`ACMP_IRQ_EVENT] = state_ff.evt_status;
        end
        else if (sel_mask)
        begin
            read_mux[`ACMP_IRQ_EVENT] = state_ff.evt_mask;
        end
    end

    // Stop2 loads these; the synchroniser keeps running
    // Reset values of the whole state
    always_comb
    begin
        reset_state = state_ff;
        reset_state.enable = `ACMP_RST_BIT;
        reset_state.ref_sel = `ACMP_RST_BIT;
        reset_state.flag = `ACMP_RST_BIT;
        reset_state.irq_en = `ACMP_RST_BIT;
        reset_state.pin_en = `ACMP_RST_BIT;
        reset_state.edge_mode = `ACMP_RST_MODE;
        reset_state.armed = `ACMP_RST_BIT;
        reset_state.prev_level = `ACMP_RST_BIT;
        reset_state.pin_value = `ACMP_RST_BIT;
        reset_state.pin_oe = `ACMP_RST_BIT;
        reset_state.evt_status = `ACMP_RST_BIT;
        reset_state.evt_mask = `ACMP_RST_BIT;
        reset_state.rdata = `ACMP_RST_BYTE;
    end

    // Next state
    always_comb
    begin
        nxt_state = state_ff;
        // Read data returns to zero outside the read slot
        nxt_state.rdata = `ACMP_RST_BYTE;

        // Read data stands one cycle after the strobe
        if (req.rd)
        begin
            nxt_state.rdata = read_mux;
        end

        // Read of the interrupt status clears it
        if (rd_status)
        begin
            nxt_state.evt_status = 1'h0;
        end

        // Software writes
        // Level bit is read only, so writes to it are ignored
        if (wr_sc)
        begin
            nxt_state.enable = req.wdata[`ACMP_SC_ENABLE];
            nxt_state.ref_sel = req.wdata[`ACMP_SC_REF_SEL];
            nxt_state.irq_en = req.wdata[`ACMP_SC_IRQ_EN];
            nxt_state.pin_en = req.wdata[`ACMP_SC_PIN_EN];
            nxt_state.edge_mode = req.wdata[`ACMP_SC_MODE_HI:`ACMP_SC_MODE_LO];
            if (req.wdata[`ACMP_SC_FLAG])
            begin
                nxt_state.flag = 1'b0;
            end
        end
        if (wr_mask)
        begin
            nxt_state.evt_mask = req.wdata[`ACMP_IRQ_EVENT];
        end

        // Cleared while idle so enabling never compares against old data
        // track level only while enabled
        nxt_state.armed = active;
        nxt_state.prev_level = active ? live_level : 1'b0;

        if (event_hit)
        begin
            nxt_state.flag = 1'b1;
            nxt_state.evt_status = 1'b1;
        end

        // drive result only when pin enabled
        nxt_state.pin_oe = active & state_ff.pin_en;
        nxt_state.pin_value = active & state_ff.pin_en & live_level;

        // Held prev_level lets a change across stop3 show after exit
        // stop3 holds registers except read data and pin drive, which clear; clocks halted
        if (mode.stop3_mode)
        begin
            nxt_state = state_ff;
            nxt_state.rdata = `ACMP_RST_BYTE;
            nxt_state.pin_oe = 1'b0;
            nxt_state.pin_value = 1'b0;
        end

        // stop2 powers down to reset values
        if (mode.stop2_mode)
        begin
            nxt_state = reset_state;
        end
    end

    // reset during stop3 returns to reset state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff.enable <= `ACMP_RST_BIT;
            state_ff.ref_sel <= `ACMP_RST_BIT;
            state_ff.flag <= `ACMP_RST_BIT;
            state_ff.irq_en <= `ACMP_RST_BIT;
            state_ff.pin_en <= `ACMP_RST_BIT;
            state_ff.edge_mode <= `ACMP_RST_MODE;
            state_ff.armed <= `ACMP_RST_BIT;
            state_ff.prev_level <= `ACMP_RST_BIT;
            state_ff.pin_value <= `ACMP_RST_BIT;
            state_ff.pin_oe <= `ACMP_RST_BIT;
            state_ff.evt_status <= `ACMP_RST_BIT;
            state_ff.evt_mask <= `ACMP_RST_BIT;
            state_ff.rdata <= `ACMP_RST_BYTE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Analog cell controls
    always_comb
    begin
        analog_ctl.power_on = active;
        analog_ctl.minus_from_pin = 1'b1;
        analog_ctl.plus_from_pin = ~state_ff.ref_sel;
        // bandgap buffer is enabled by software elsewhere
        analog_ctl.plus_from_bandgap = state_ff.ref_sel;
    end

    assign out_pin.value = state_ff.pin_value;
    assign out_pin.oe = state_ff.pin_oe;

    assign rdata = state_ff.rdata;

    // interrupt level also wakes from wait
    always_comb
    begin
        irq = 1'h0;
        if (state_ff.flag && state_ff.irq_en)
        begin
            irq = 1'h1;
        end
        // Interrupt status and mask add a second source
        if (state_ff.evt_status && state_ff.evt_mask)
        begin
            irq = 1'h1;
        end
    end

endmodule : analog_comparator_control

// ### acmp_ctl_checker.sv
// Port assertions for the comparator control block, bound to its top.
// Assumes one clock and an asynchronous active-high reset.
`include "acmp_defines.svh"

module acmp_ctl_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire acmp_pkg::reg_req_t req,
    input wire logic [`ACMP_DATA_W-1:0] rdata,
    input wire acmp_pkg::power_mode_t mode,
    input wire logic cmp_result,
    input wire acmp_pkg::analog_ctl_t analog_ctl,
    input wire acmp_pkg::pin_out_t out_pin,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import acmp_pkg::*;
    logic stp;
    assign stp = mode.stop2_mode | mode.stop3_mode;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_route;
        analog_ctl.minus_from_pin
            && (analog_ctl.plus_from_pin != analog_ctl.plus_from_bandgap);
    endproperty
    a_route: assert property (p_route)
        else $error("input routing wrong");
    property p_idle;
        !req.rd |=> rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle)
        else $error("read data outside read slot");
    property p_level;
        !rdata[`ACMP_SC_ENABLE] |-> !rdata[`ACMP_SC_LEVEL];
    endproperty
    a_level: assert property (p_level)
        else $error("level bit set while disabled");
    property p_irq;
        req.rd && req.addr == `ACMP_OFS_SC
            |=> !(rdata[`ACMP_SC_FLAG] && rdata[`ACMP_SC_IRQ_EN]) || irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("flag and enable without interrupt");
    property p_hold;
        mode.stop3_mode ##1 mode.stop3_mode |-> $stable(irq) && !out_pin.oe;
    endproperty
    a_hold: assert property (p_hold)
        else $error("state moved in stop3");
    property p_off;
        stp ##1 stp |-> !analog_ctl.power_on;
    endproperty
    a_off: assert property (p_off)
        else $error("comparator powered in stop");
    property p_stop2;
        mode.stop2_mode |=> !irq && !out_pin.oe && rdata == 8'h00;
    endproperty
    a_stop2: assert property (p_stop2)
        else $error("state kept in stop2");
    property p_pin;
        req.wr && req.addr == `ACMP_OFS_SC && req.wdata[`ACMP_SC_ENABLE]
            && req.wdata[`ACMP_SC_PIN_EN] && !stp ##1 (!req.wr && !stp)[*2]
            |-> out_pin.oe;
    endproperty
    a_pin: assert property (p_pin)
        else $error("output pin not driven");
endmodule : acmp_ctl_checker

bind analog_comparator_control acmp_ctl_checker acmp_ctl_checker_i (
    .clk(clk), .rst(rst), .req(req), .rdata(rdata), .mode(mode), .irq(irq),
    .cmp_result(cmp_result), .analog_ctl(analog_ctl), .out_pin(out_pin)
);

// ### analog_source_model.sv
// Analog side: pin voltages in millivolts and the comparator cell.
// Assumes the bench drives the voltages; bandgap level is a plain default.
module analog_source_model #(
    parameter logic [15:0] BG_MV = 16'h04b0
) (
    // Pin voltages and bandgap buffer
    input wire logic [15:0] plus_mv,
    input wire logic [15:0] minus_mv,
    input wire logic bg_buf_en,
    // Cell control and result
    input wire acmp_pkg::analog_ctl_t ctl,
    output logic result
);
    timeunit 1ns;
    timeprecision 1ns;
    import acmp_pkg::*;
    logic [15:0] pos_mv;
    always_comb
    begin
        pos_mv = bg_buf_en ? BG_MV : 16'h0000;
        if (ctl.plus_from_pin)
        begin
            pos_mv = plus_mv;
        end
        result = ctl.power_on && ctl.minus_from_pin && pos_mv > minus_mv;
    end
endmodule : analog_source_model

// ### tb_top.sv
// Self-checking bench for the comparator control block.
// Assumes design, checker and analog model are compiled before it.
`include "acmp_defines.svh"
`define CHK(nm, ex, got) \
    cmp_count++; \
    if ((got) !== (ex)) \
    begin \
        $display("[ERR] %s exp %h got %h", nm, ex, got); \
        failures++; \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import acmp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    power_mode_t mode = '0;
    logic [15:0] plus_mv = 16'h0064;
    logic [15:0] minus_mv = 16'h01f4;
    logic bg_buf_en = 1'b1;
    logic [7:0] rdata;
    logic [7:0] d;
    logic cmp_result;
    logic irq;
    analog_ctl_t analog_ctl;
    pin_out_t out_pin;
    int failures = 0;
    int cmp_count = 0;

    always #50 clk = ~clk;

    analog_comparator_control analog_comparator_control_i (
        .clk(clk), .rst(rst), .req(req), .rdata(rdata), .mode(mode), .irq(irq),
        .cmp_result(cmp_result), .analog_ctl(analog_ctl), .out_pin(out_pin)
    );
    analog_source_model analog_source_model_i (
        .plus_mv(plus_mv), .minus_mv(minus_mv), .bg_buf_en(bg_buf_en),
        .ctl(analog_ctl), .result(cmp_result)
    );

    task automatic finish_test;
        if (failures == 0 && cmp_count > 0)
        begin
            $display("Simulation passed");
        end
        else
        begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= v;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    // Move the plus pin, then wait for the output pin to follow
    task automatic vin(input logic [15:0] mv, input logic v);
        int n;
        n = 0;
        @(posedge clk);
        plus_mv <= mv;
        while (out_pin.value !== v && n < 30)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (out_pin.value !== v)
        begin
            failures++;
            finish_test();
        end
        repeat (2) @(posedge clk);
    endtask : vin

    task automatic t_reset;
        for (int a = 0; a < 4; a++)
        begin
            rd(4'(a));
            `CHK("reset", 8'h00, d)
        end
        rd(4'hf);
        `CHK("unmapped", 8'h00, d)
        `CHK("ctl", 4'h5, analog_ctl)
        wr(4'h0, 8'h17);
        rd(4'h0);
        `CHK("fields", 8'h17, d)
        `CHK("oe off", 1'b0, out_pin.oe)
        wr(4'h0, 8'h57);
        `CHK("bandgap", 4'h3, analog_ctl)
        wr(4'h0, 8'h00);
    endtask : t_reset

    task automatic t_edges;
        logic [1:0] m;
        for (int i = 0; i < 4; i++)
        begin
            m = 2'(i);
            @(posedge clk);
            mode.wait_mode <= m[0];
            mode.debug_active <= m[1];
            wr(4'h0, {6'h25, m});
            vin(16'h0384, 1'b1);
            wr(4'h0, {6'h25, m});
            rd(4'h0);
            `CHK("rise", {2'h2, m[0], 3'h7, m}, d)
            `CHK("rise irq", m[0], irq)
            `CHK("pin", 2'h3, out_pin)
            wr(4'h0, {6'h2d, m});
            vin(16'h0064, 1'b0);
            rd(4'h0);
            `CHK("fall", {2'h2, m != 2'h1, 3'h5, m}, d)
            wr(4'h0, 8'h20);
        end
    endtask : t_edges

    task automatic t_irq;
        rd(4'h1);
        wr(4'h0, 8'h87);
        vin(16'h0384, 1'b1);
        `CHK("masked", 1'b0, irq)
        wr(4'h2, 8'h01);
        `CHK("unmasked", 1'b1, irq)
        rd(4'h2);
        `CHK("mask", 8'h01, d)
        rd(4'h1);
        `CHK("status", 8'h01, d)
        `CHK("read clr", 1'b0, irq)
        rd(4'h1);
        `CHK("status2", 8'h00, d)
        wr(4'h2, 8'h00);
        wr(4'h0, 8'h20);
        vin(16'h0064, 1'b0);
    endtask : t_irq

    task automatic t_bandgap;
        wr(4'h0, 8'hc4);
        vin(16'h0064, 1'b1);
        rd(4'h0);
        `CHK("bandgap lvl", 8'hcc, d)
        `CHK("bandgap ctl", 4'hb, analog_ctl)
        wr(4'h0, 8'h20);
        repeat (6) @(posedge clk);
    endtask : t_bandgap

    task automatic t_stop3;
        wr(4'h0, 8'h95);
        @(posedge clk);
        mode.stop3_mode <= 1'b1;
        plus_mv <= 16'h0384;
        repeat (10) @(posedge clk);
        #1;
        `CHK("stop3 pin", 2'h0, out_pin)
        `CHK("stop3 irq", 1'b0, irq)
        rd(4'h0);
        `CHK("stop3 rd", 8'h00, d)
        @(posedge clk);
        mode.stop3_mode <= 1'b0;
        vin(16'h0384, 1'b1);
        rd(4'h0);
        `CHK("resume", 8'hbd, d)
        @(posedge clk);
        mode.stop3_mode <= 1'b1;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        mode.stop3_mode <= 1'b0;
        rd(4'h0);
        `CHK("stop3 reset", 8'h00, d)
    endtask : t_stop3

    task automatic t_stop2;
        wr(4'h0, 8'h95);
        wr(4'h2, 8'h01);
        @(posedge clk);
        mode.stop2_mode <= 1'b1;
        repeat (3) @(posedge clk);
        mode.stop2_mode <= 1'b0;
        for (int a = 0; a < 3; a++)
        begin
            rd(4'(a));
            `CHK("stop2", 8'h00, d)
        end
    endtask : t_stop2

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_edges();
        t_irq();
        t_bandgap();
        t_stop3();
        t_stop2();
        finish_test();
    end
endmodule : tb_top
